// ===== inc/pbc_defs.svh
/*
  constants for the phy basic control register: address, bit positions,
  write mask and management frame field values.
  assumes the management clock is sampled as an ordinary synchronous input.
*/
`ifndef PBC_DEFS_SVH
`define PBC_DEFS_SVH
`define PBC_REG_ADDR   5'h00
`define PBC_BIT_RESET  15
`define PBC_BIT_LOOP   14
`define PBC_BIT_SPEED  13
`define PBC_BIT_ANEN   12
`define PBC_BIT_PDOWN  11
`define PBC_BIT_ISO    10
`define PBC_BIT_RSTAN  9
`define PBC_BIT_DUPLEX 8
`define PBC_BIT_COLT   7
`define PBC_WMASK      16'hBF80
`define PBC_OP_WRITE   2'h1
`define PBC_OP_READ    2'h2
`define PBC_PRE_LEN    6'h20
`define PBC_HDR_LEN    6'h0E
`define PBC_TA_LEN     6'h02
`define PBC_DATA_LEN   6'h10
`endif

// ===== inc/pbc_pkg.sv
/*
  types for the phy basic control register.
  assumes pbc_defs.svh supplies the numeric constants.
*/
package pbc_pkg;
  typedef struct packed {
    logic speed;
    logic autoneg;
    logic isolate;
    logic duplex_n;
  } pbc_strap_t;
  typedef struct packed {
    logic loopback;
    logic speed_100;
    logic autoneg_en;
    logic power_down;
    logic isolate;
    logic full_duplex;
    logic col_test;
  } pbc_ctrl_t;
  typedef enum logic [2:0] {
    PBC_IDLE,
    PBC_HDR,
    PBC_TA,
    PBC_DATA,
    PBC_SKIP
  } pbc_state_t;
endpackage

// ===== core/pbc_basic_control.sv
/*
  basic control register of a 10/100 phy with its serial management slave.
  assumes mdc, mdio_in and straps are synchronous to clk; a negotiation
  engine and datapath outside consume the mode outputs.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pbc_defs.svh"
module pbc_basic_control #(
  parameter logic [4:0] PHY_ADDR = 5'h01
) (
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic            mdc,
  input  wire logic            mdio_in,
  output logic                 mdio_out,
  output logic                 mdio_oe,
  input  wire pbc_pkg::pbc_strap_t straps,
  output pbc_pkg::pbc_ctrl_t   ctrl,
  output logic                 eff_speed_100,
  output logic                 eff_full_duplex,
  output logic                 soft_reset_pulse,
  output logic                 an_restart_pulse
);
  if (PHY_ADDR > 5'h1F) begin : g_bad_phy_addr
    $error("bad phy address");
  end

  pbc_pkg::pbc_state_t state_reg;
  logic                mdc_reg;
  logic [5:0]          cnt_reg;
  logic [13:0]         hdr_reg;
  logic [15:0]         sh_reg;
  logic                is_write_reg;
  logic                sel_reg;
  logic                strap_load_reg;
  logic                wr_stb;
  logic [15:0]         wr_data;
  logic                rise;
  logic [15:0]         rd_word;
  logic [13:0]         hdr_full;
  logic                op_rd;
  logic                op_wr;

  function automatic logic hit(input logic [13:0] h);
    hit = (h[13:12] == 2'h1) && (h[9:5] == PHY_ADDR) && (h[4:0] == `PBC_REG_ADDR);
  endfunction

  // mdc rise as seen by clk
  assign rise = mdc & ~mdc_reg;
  // header word with the bit now on the line
  assign hdr_full = {hdr_reg[12:0], mdio_in};
  assign op_rd    = hdr_full[11:10] == `PBC_OP_READ;
  assign op_wr    = hdr_full[11:10] == `PBC_OP_WRITE;

  always_comb begin
    rd_word = 16'h0000;
    rd_word[`PBC_BIT_LOOP]   = ctrl.loopback;
    rd_word[`PBC_BIT_SPEED]  = ctrl.speed_100;
    rd_word[`PBC_BIT_ANEN]   = ctrl.autoneg_en;
    rd_word[`PBC_BIT_PDOWN]  = ctrl.power_down;
    rd_word[`PBC_BIT_ISO]    = ctrl.isolate;
    rd_word[`PBC_BIT_DUPLEX] = ctrl.full_duplex;
    rd_word[`PBC_BIT_COLT]   = ctrl.col_test;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mdc_reg <= 1'b0;
    end else begin
      mdc_reg <= mdc;
    end
  end

  // management frame: preamble ones, 01 start, op, phy, reg, turnaround, data
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg    <= pbc_pkg::PBC_IDLE;
      cnt_reg      <= 6'h00;
      hdr_reg      <= 14'h0000;
      sh_reg       <= 16'h0000;
      is_write_reg <= 1'b0;
      sel_reg      <= 1'b0;
      mdio_out     <= 1'b0;
      mdio_oe      <= 1'b0;
      wr_stb       <= 1'b0;
      wr_data      <= 16'h0000;
    end else begin
      wr_stb <= 1'b0;
      if (rise) begin
        unique case (state_reg)
          pbc_pkg::PBC_IDLE: begin
            // preamble count saturates, longer runs of ones pass
            if (mdio_in) begin
              if (cnt_reg < `PBC_PRE_LEN) cnt_reg <= cnt_reg + 6'h01;
            end else if (cnt_reg == `PBC_PRE_LEN) begin
              state_reg <= pbc_pkg::PBC_HDR;
              cnt_reg   <= 6'h01;
              hdr_reg   <= 14'h0000;
            end else begin
              cnt_reg <= 6'h00;
            end
          end
          pbc_pkg::PBC_HDR: begin
            hdr_reg <= hdr_full;
            cnt_reg <= cnt_reg + 6'h01;
            if (cnt_reg == `PBC_HDR_LEN - 6'h01) begin
              is_write_reg <= op_wr;
              sel_reg      <= hit(hdr_full) && (op_wr || op_rd);
              state_reg    <= pbc_pkg::PBC_TA;
              cnt_reg      <= 6'h00;
              if (hit(hdr_full) && op_rd) begin
                sh_reg <= rd_word;
              end
            end
          end
          pbc_pkg::PBC_TA: begin
            cnt_reg <= cnt_reg + 6'h01;
            // read turnaround drives zero in its second bit
            if (cnt_reg == 6'h00 && sel_reg && !is_write_reg) begin
              mdio_oe  <= 1'b1;
              mdio_out <= 1'b0;
            end
            if (cnt_reg == `PBC_TA_LEN - 6'h01) begin
              state_reg <= pbc_pkg::PBC_DATA;
              cnt_reg   <= 6'h00;
              if (sel_reg && !is_write_reg) begin
                mdio_out <= sh_reg[15];
                sh_reg   <= {sh_reg[14:0], 1'b0};
              end
            end
          end
          pbc_pkg::PBC_DATA: begin
            cnt_reg <= cnt_reg + 6'h01;
            if (is_write_reg) begin
              sh_reg <= {sh_reg[14:0], mdio_in};
            end else if (mdio_oe) begin
              mdio_out <= sh_reg[15];
              sh_reg   <= {sh_reg[14:0], 1'b0};
            end
            if (cnt_reg == `PBC_DATA_LEN - 6'h01) begin
              state_reg <= pbc_pkg::PBC_IDLE;
              cnt_reg   <= 6'h00;
              mdio_oe   <= 1'b0;
              mdio_out  <= 1'b0;
              // write data lands with the last data bit
              if (is_write_reg && sel_reg) begin
                wr_stb  <= 1'b1;
                wr_data <= {sh_reg[14:0], mdio_in};
              end
            end
          end
          default: begin
            state_reg <= pbc_pkg::PBC_IDLE;
            cnt_reg   <= 6'h00;
          end
        endcase
      end
    end
  end

  // straps are relatched one cycle after hardware or software reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strap_load_reg <= 1'b1;
    end else begin
      strap_load_reg <= soft_reset_pulse;
    end
  end

  // control bits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= '0;
    end else if (strap_load_reg) begin
      ctrl.loopback    <= 1'b0;
      ctrl.col_test    <= 1'b0;
      ctrl.power_down  <= 1'b0;
      ctrl.speed_100   <= straps.speed;
      ctrl.autoneg_en  <= straps.autoneg;
      ctrl.isolate     <= straps.isolate;
      ctrl.full_duplex <= ~straps.duplex_n;
    end else if (wr_stb && !wr_data[`PBC_BIT_RESET]) begin
      ctrl.loopback    <= wr_data[`PBC_BIT_LOOP];
      ctrl.speed_100   <= wr_data[`PBC_BIT_SPEED];
      ctrl.autoneg_en  <= wr_data[`PBC_BIT_ANEN];
      ctrl.power_down  <= wr_data[`PBC_BIT_PDOWN];
      ctrl.isolate     <= wr_data[`PBC_BIT_ISO];
      ctrl.full_duplex <= wr_data[`PBC_BIT_DUPLEX];
      ctrl.col_test    <= wr_data[`PBC_BIT_COLT];
    end else if (wr_stb && ctrl.power_down) begin
      // a reset request during power-down only wakes the device
      ctrl.power_down <= 1'b0;
    end
  end

  // self-clearing bits leave as one-cycle pulses
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      soft_reset_pulse <= 1'b0;
      an_restart_pulse <= 1'b0;
    end else begin
      soft_reset_pulse <= wr_stb && wr_data[`PBC_BIT_RESET] && !ctrl.power_down;
      an_restart_pulse <= wr_stb && !wr_data[`PBC_BIT_RESET] && wr_data[`PBC_BIT_RSTAN];
    end
  end

  // effective speed and duplex follow the control bits when negotiation is off; they hold their value otherwise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      eff_speed_100   <= 1'b0;
      eff_full_duplex <= 1'b0;
    end else if (!ctrl.autoneg_en) begin
      eff_speed_100   <= ctrl.speed_100;
      eff_full_duplex <= ctrl.full_duplex;
    end
  end
endmodule // pbc_basic_control
`default_nettype wire

// ===== tb/pbc_chk.sv
/*
  port checker for the basic control register.
  assumes one clock domain and an active high asynchronous reset.
*/
`timescale 1ns/10ps
`default_nettype none
module pbc_chk (
  input wire logic                clk,
  input wire logic                rst,
  input wire logic                mdc,
  input wire logic                mdio_in,
  input wire logic                mdio_out,
  input wire logic                mdio_oe,
  input wire pbc_pkg::pbc_strap_t straps,
  input wire pbc_pkg::pbc_ctrl_t  ctrl,
  input wire logic                eff_speed_100,
  input wire logic                eff_full_duplex,
  input wire logic                soft_reset_pulse,
  input wire logic                an_restart_pulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence relatch_s;
    ##[1:2] (ctrl.speed_100 == straps.speed && ctrl.autoneg_en == straps.autoneg
      && ctrl.isolate == straps.isolate && ctrl.full_duplex == !straps.duplex_n
      && !ctrl.loopback && !ctrl.power_down && !ctrl.col_test);
  endsequence
  sequence calm_s;
    (!ctrl.autoneg_en && $stable(ctrl) && !soft_reset_pulse) [*3];
  endsequence
  sr_pulse_a: assert property (soft_reset_pulse |=> !soft_reset_pulse)
    else $error("soft reset pulse too long");
  sr_relatch_a: assert property (soft_reset_pulse |-> relatch_s)
    else $error("straps not relatched");
  an_pulse_a: assert property (an_restart_pulse |=> !an_restart_pulse)
    else $error("restart pulse too long");
  eff_follow_a: assert property (calm_s |->
    eff_speed_100 == ctrl.speed_100 && eff_full_duplex == ctrl.full_duplex)
    else $error("effective mode not following");
  eff_hold_a: assert property (ctrl.autoneg_en && $past(ctrl.autoneg_en) && !$past(soft_reset_pulse)
    && !$past(soft_reset_pulse, 2) |-> $stable(eff_speed_100) && $stable(eff_full_duplex))
    else $error("effective mode moved under negotiation");
  pd_exit_a: assert property ($fell(ctrl.power_down) |-> !soft_reset_pulse ##1 !soft_reset_pulse)
    else $error("power-down exit caused reset");
  sr_outside_a: assert property (soft_reset_pulse |-> !ctrl.power_down)
    else $error("reset during power-down");
  oe_turn_a: assert property ($rose(mdio_oe) |-> !mdio_out)
    else $error("turnaround not zero");
  idle_release_a: assert property (!mdc [*8] |-> !mdio_oe)
    else $error("data line driven while idle");
endmodule // pbc_chk
bind pbc_basic_control pbc_chk chk_i (.clk(clk), .rst(rst), .mdc(mdc), .mdio_in(mdio_in),
  .mdio_out(mdio_out), .mdio_oe(mdio_oe), .straps(straps), .ctrl(ctrl), .eff_speed_100(eff_speed_100),
  .eff_full_duplex(eff_full_duplex), .soft_reset_pulse(soft_reset_pulse), .an_restart_pulse(an_restart_pulse));
`default_nettype wire

// ===== tb/pbc_host.sv
/*
  station management host model issuing serial management frames.
  assumes mdio_w is the resolved data line level.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pbc_defs.svh"
module pbc_host (
  input  wire logic clk,
  input  wire logic mdio_w,
  output var  logic mdc,
  output var  logic mdo
);
  initial begin
    mdc = 1'b0;
    mdo = 1'b1;
  end
  // released line shows the inverse of the last value
  task automatic bit_x(input logic drv, input logic b, output logic s);
    mdo = drv ? b : ~mdo;
    repeat (4) @(negedge clk);
    s = mdio_w;
    mdc = 1'b1;
    repeat (4) @(negedge clk);
    mdc = 1'b0;
  endtask
  task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                      input logic [15:0] wd, output logic [15:0] rd);
    logic [13:0] hdr;
    logic        s;
    logic        w;
    hdr = {2'b01, op, pa, ra};
    w = (op == `PBC_OP_WRITE);
    repeat (32) bit_x(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) bit_x(1'b1, hdr[i], s);
    bit_x(w, 1'b1, s);
    bit_x(w, 1'b0, s);
    for (int i = 15; i >= 0; i--) begin
      bit_x(w, wd[i], s);
      rd[i] = s;
    end
    repeat (4) @(negedge clk);
  endtask
endmodule // pbc_host
`default_nettype wire

// ===== tb/testbench.sv
/*
  self-checking bench for the basic control register.
  assumes pbc_host as management master and the bound checker.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pbc_defs.svh"
module testbench;
  logic               clk, rst, mdio_out, mdio_oe, mdio_w, mdc, mdo, eff_s, eff_d, srp, anp;
  pbc_pkg::pbc_strap_t straps;
  pbc_pkg::pbc_ctrl_t  ctrl;
  int                 mismatches, num_checks;
  logic [15:0]        cur, rd;
  int                 srp_n = 0;
  int                 anp_n = 0;
  pbc_basic_control dut (.clk(clk), .rst(rst), .mdc(mdc), .mdio_in(mdio_w), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe), .straps(straps), .ctrl(ctrl), .eff_speed_100(eff_s), .eff_full_duplex(eff_d),
    .soft_reset_pulse(srp), .an_restart_pulse(anp));
  pbc_host host (.clk(clk), .mdio_w(mdio_w), .mdc(mdc), .mdo(mdo));
  assign mdio_w = mdio_oe ? mdio_out : mdo;
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    if (srp === 1'b1) srp_n <= srp_n + 1;
    if (anp === 1'b1) anp_n <= anp_n + 1;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  function automatic logic [15:0] strap_val(input pbc_pkg::pbc_strap_t s);
    return {2'h0, s.speed, s.autoneg, 1'b0, s.isolate, 1'b0, ~s.duplex_n, 8'h00};
  endfunction
  function automatic logic [15:0] nxt(input logic [15:0] c, input logic [15:0] d);
    if (d[15] && c[11]) return c & 16'hF7FF;
    if (d[15]) return strap_val(straps);
    return d & 16'h7D80;
  endfunction
  task automatic verify();
    host.xfer(`PBC_OP_READ, 5'h01, 5'h00, 16'h0000, rd);
    chk(rd, cur);
    chk({9'h000, ctrl}, {9'h000, cur[14:10], cur[8:7]});
    if (!cur[12]) chk({14'h0000, eff_s, eff_d}, {14'h0000, cur[13], cur[8]});
  endtask
  task automatic wr(input logic [15:0] d);
    int s0;
    int a0;
    s0 = srp_n;
    a0 = anp_n;
    host.xfer(`PBC_OP_WRITE, 5'h01, 5'h00, d, rd);
    chk(16'(srp_n - s0), {15'h0000, d[15] & ~cur[11]});
    chk(16'(anp_n - a0), {15'h0000, ~d[15] & d[9]});
    cur = nxt(cur, d);
    verify();
  endtask
  initial begin
    #2000000;
    mismatches++;
    end_sim();
  end
  initial begin
    rst = 1'b1;
    mismatches = 0;
    num_checks = 0;
    void'($urandom(32'h42CCA180));
    straps = 4'($urandom);
    repeat (20) @(negedge clk);
    rst = 1'b0;
    cur = strap_val(straps);
    verify();
    $display("test reset values done");
    repeat (12) begin
      straps = 4'($urandom);
      wr(16'($urandom));
    end
    $display("test random writes done");
    wr(16'h0800);
    wr(16'h8000);
    wr(16'h8000);
    wr(16'h0200);
    wr(16'h7FFF);
    $display("test corners done");
    host.xfer(`PBC_OP_WRITE, 5'h02, 5'h00, 16'h0000, rd);
    verify();
    host.xfer(`PBC_OP_WRITE, 5'h01, 5'h01, 16'h0000, rd);
    verify();
    $display("test foreign frames done");
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    cur = strap_val(straps);
    verify();
    $display("test second reset done");
    end_sim();
  end
endmodule // testbench
`default_nettype wire
